// ### rtl/banked_register_file.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module banked_register_file
  import regfile_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // Datapath side.
  input wire logic instr_start,
  input wire logic [7:0] src_field,
  input wire logic src_is_work,
  input wire logic src_word,
  input wire logic [7:0] dst_field,
  input wire logic dst_is_work,
  input wire logic dst_word,
  input wire logic dst_we,
  input wire logic [15:0] dst_data,
  input wire logic set_window_base_instr,
  input wire logic [7:0] set_window_value,
  input wire logic [7:0] port01_addr_mask,
  input wire logic [7:0] port_wprotect_mask,
  input wire logic guard_option,
  output logic [15:0] src_data,
  output logic [7:0] window_pointer,
  output logic guard_active,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef struct packed {
    logic [7:0] wptr;
    logic [3:0] group_live;
    logic [7:0] int_mask;
    logic [7:0] ctrl_f0;
    logic [7:0] ctrl_f1;
    logic [7:0] stack_hi;
    logic [7:0] stack_lo;
    logic [15:0] src_q;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic guard;
  } state_t;
  state_t st;
  state_t next_st;

  logic [7:0] bank_mem [0:15][0:15];
  logic [7:0] s_addr;
  logic [7:0] d_addr;
  logic [7:0] wb_addr;
  logic [7:0] ram_rdata_a;
  logic [7:0] ram_rdata_b;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_wmask;
  logic ram_we;
  logic pair_we;
  logic [7:0] pair_addr;
  logic [7:0] pair_wmask;
  logic wb_req;
  logic wb_hit;

  // Working decode uses the group latched at instruction start.
  addr_former u_src (
    .field(src_field),
    .is_work(src_is_work),
    .group_nibble(st.group_live),
    .addr(s_addr)
  );
  addr_former u_dst (
    .field(dst_field),
    .is_work(dst_is_work),
    .group_nibble(st.group_live),
    .addr(d_addr)
  );

  assign wb_req = wb_cyc_i && wb_stb_i && !st.wb_ack;
  assign wb_hit = (wb_adr_i[11:10] == 2'b00) && (wb_adr_i[1:0] == 2'b00) && wb_sel_i[0];
  assign wb_addr = wb_adr_i[9:2];

  function automatic logic is_wo(input logic [7:0] a);
    is_wo = (a == OFS_WO_F3) || (a >= OFS_WO_FIRST && a <= OFS_WO_LAST);
  endfunction

  function automatic logic guarded(input logic [7:0] a, input logic [7:0] mask_v,
                                   input logic opt);
    guarded = opt && mask_v[RAM_GUARD_BIT] && a >= GUARD_FIRST && a <= SCRATCH_LAST;
  endfunction

  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] wp);
    in_bank = (wp[3:0] != 4'h0) && (a <= 8'h0f);
  endfunction

  // Two read ports: one for the datapath, one shared by word-pair low byte and the bus.
  scratch_ram u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .wmask(ram_wmask),
    .pair_we(pair_we),
    .pair_waddr(pair_addr),
    .pair_wdata(dst_data[7:0]),
    .pair_wmask(pair_wmask),
    .raddr(s_addr),
    .rdata(ram_rdata_a)
  );
  scratch_ram u_ram_b (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .wmask(ram_wmask),
    .pair_we(pair_we),
    .pair_waddr(pair_addr),
    .pair_wdata(dst_data[7:0]),
    .pair_wmask(pair_wmask),
    .raddr(wb_req ? wb_addr : (s_addr | 8'h01)),
    .rdata(ram_rdata_b)
  );

  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] ram_v,
                                         input state_t s);
    logic [7:0] v;
    v = ram_v;
    if (in_bank(a, s.wptr)) begin
      v = bank_mem[s.wptr[3:0]][a[3:0]];
    end else if (is_wo(a)) begin
      v = WO_READ_VALUE;
    end else if (a >= CTRL_FIRST) begin
      unique case (a)
        OFS_SIO: v = s.ctrl_f0;
        OFS_TIMER_MODE: v = s.ctrl_f1;
        OFS_INTERRUPT_MASK_REG: v = s.int_mask;
        OFS_WINDOW_POINTER: v = s.wptr;
        OFS_STACK_POINTER_HIGH: v = s.stack_hi;
        OFS_STACK_POINTER_LOW: v = s.stack_lo;
        default: v = UNMAPPED_READ_VALUE;
      endcase
    end else if (guarded(a, s.int_mask, guard_option)) begin
      v = GUARD_READ_VALUE;
    end else if (a <= 8'h01) begin
      v = ram_v | port01_addr_mask;
    end
    return v;
  endfunction

  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr2_en;
  logic [7:0] wr2_byte;

  always_comb begin
    // Datapath write has priority over the bus; the bus only answers the read or a free slot.
    wr_en = dst_we;
    wr_addr = dst_word ? {d_addr[7:1], 1'b0} : d_addr;
    wr_byte = dst_word ? dst_data[15:8] : dst_data[7:0];
    wr2_en = dst_we && dst_word;
    wr2_byte = dst_data[7:0];
    if (!dst_we && wb_req && wb_hit && wb_we_i) begin
      wr_en = 1'b1;
      wr_addr = wb_addr;
      wr_byte = wb_dat_i[7:0];
    end
    if (guarded(wr_addr, st.int_mask, guard_option)) begin
      wr_en = 1'b0;
      wr2_en = 1'b0;
    end
  end

  assign pair_addr = {wr_addr[7:1], 1'b1};

  // Port protection is a bit mask on the RAM write, so it does not depend on the source operand.
  always_comb begin
    ram_we = wr_en && !in_bank(wr_addr, st.wptr) && wr_addr < CTRL_FIRST;
    ram_waddr = wr_addr;
    ram_wdata = wr_byte;
    ram_wmask = 8'hff;
    if (wr_addr <= PORT_LAST) begin
      ram_wmask = ~port_wprotect_mask;
    end
    pair_we = wr2_en && !in_bank(pair_addr, st.wptr) && pair_addr < CTRL_FIRST;
    pair_wmask = 8'hff;
    if (pair_addr <= PORT_LAST) begin
      pair_wmask = ~port_wprotect_mask;
    end
  end

  // Bank registers are plain storage like the scratch RAM, so they take no reset either.
  always_ff @(posedge core_clk) begin
    if (wr_en && in_bank(wr_addr, st.wptr)) begin
      bank_mem[st.wptr[3:0]][wr_addr[3:0]] <= wr_byte;
    end
    if (wr2_en && in_bank(pair_addr, st.wptr)) begin
      bank_mem[st.wptr[3:0]][pair_addr[3:0]] <= wr2_byte;
    end
  end

  logic [7:0] pair_lo;
  assign pair_lo = rd_byte(s_addr | 8'h01, ram_rdata_b, st);

  always_comb begin
    next_st = st;
    if (instr_start) begin
      next_st.group_live = st.wptr[7:4];
    end
    if (src_word) begin
      next_st.src_q = {rd_byte({s_addr[7:1], 1'b0}, ram_rdata_a, st), pair_lo};
    end else begin
      next_st.src_q = {8'h00, rd_byte(s_addr, ram_rdata_a, st)};
    end
    if (wr_en) begin
      unique case (wr_addr)
        OFS_SIO: next_st.ctrl_f0 = wr_byte;
        OFS_TIMER_MODE: next_st.ctrl_f1 = wr_byte;
        OFS_INTERRUPT_MASK_REG: next_st.int_mask = wr_byte;
        OFS_WINDOW_POINTER: next_st.wptr = wr_byte;
        OFS_STACK_POINTER_HIGH: next_st.stack_hi = wr_byte;
        OFS_STACK_POINTER_LOW: next_st.stack_lo = wr_byte;
        default: ;
      endcase
    end
    if (wr2_en && wr_addr == OFS_STACK_POINTER_HIGH) begin
      next_st.stack_lo = wr2_byte;
    end
    if (set_window_base_instr) begin
      next_st.wptr = set_window_value;
    end
    next_st.guard = guard_option && next_st.int_mask[RAM_GUARD_BIT];
    next_st.wb_ack = wb_req;
    if (wb_req) begin
      next_st.wb_dat = (wb_hit && !wb_we_i) ? {24'h0, rd_byte(wb_addr, ram_rdata_b, st)} : 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{wptr: WINDOW_POINTER_RESET, group_live: 4'h0, int_mask: CTRL_RESET,
              ctrl_f0: CTRL_RESET, ctrl_f1: CTRL_RESET, stack_hi: CTRL_RESET,
              stack_lo: CTRL_RESET, src_q: 16'h0000, wb_dat: 32'h0, wb_ack: 1'b0,
              guard: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign src_data = st.src_q;
  assign window_pointer = st.wptr;
  assign guard_active = st.guard;
  assign wb_dat_o = st.wb_dat;
  assign wb_ack_o = st.wb_ack;

  chk_wo_reads_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_req && wb_hit && !wb_we_i && is_wo(wb_addr) && (st.wptr[3:0] == 4'h0)
    |=> wb_dat_o[7:0] == WO_READ_VALUE)
    else $error("write-only register did not read FF");
  chk_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_srp_loads: assert property (@(posedge core_clk) disable iff (!rst_n)
    set_window_base_instr |=> window_pointer == $past(set_window_value))
    else $error("set pointer did not load");
  chk_group_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_start |=> st.group_live == $past(window_pointer[7:4]))
    else $error("group not latched at instruction start");
  chk_guard_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    guarded(wr_addr, st.int_mask, guard_option) |-> !ram_we && !pair_we)
    else $error("guarded range written");
  chk_work_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    src_is_work |-> s_addr == {st.group_live, src_field[3:0]})
    else $error("working address formed wrongly");
  chk_direct_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    !src_is_work && src_field[7:4] != DIRECT_WORK_NIBBLE |-> s_addr == src_field)
    else $error("direct address relocated");
  chk_e_nibble: assert property (@(posedge core_clk) disable iff (!rst_n)
    !src_is_work && src_field[7:4] == DIRECT_WORK_NIBBLE |-> s_addr[7:4] == st.group_live)
    else $error("E nibble not taken as working");
  cov_bus_read: cover property (@(posedge core_clk) wb_req && !wb_we_i ##1 wb_ack_o);
  cov_bank_sel: cover property (@(posedge core_clk) window_pointer[3:0] != 4'h0);
  cov_word_write: cover property (@(posedge core_clk) dst_we && dst_word);
endmodule // banked_register_file
`default_nettype wire

// ### rtl/regfile_pkg.sv
`default_nettype none
package regfile_pkg;
  localparam logic [7:0] PORT_LAST = 8'h03;
  localparam logic [7:0] SCRATCH_FIRST = 8'h04;
  localparam logic [7:0] SCRATCH_LAST = 8'hef;
  localparam logic [7:0] CTRL_FIRST = 8'hf0;
  localparam logic [7:0] GUARD_FIRST = 8'h80;
  localparam logic [3:0] DIRECT_WORK_NIBBLE = 4'he;
  localparam logic [7:0] OFS_SIO = 8'hf0;
  localparam logic [7:0] OFS_TIMER_MODE = 8'hf1;
  localparam logic [7:0] OFS_WO_F3 = 8'hf3;
  localparam logic [7:0] OFS_WO_FIRST = 8'hf5;
  localparam logic [7:0] OFS_WO_LAST = 8'hf9;
  localparam logic [7:0] OFS_INTERRUPT_MASK_REG = 8'hfb;
  localparam logic [7:0] OFS_WINDOW_POINTER = 8'hfd;
  localparam logic [7:0] OFS_STACK_POINTER_HIGH = 8'hfe;
  localparam logic [7:0] OFS_STACK_POINTER_LOW = 8'hff;
  localparam int RAM_GUARD_BIT = 6;
  localparam logic [7:0] WINDOW_POINTER_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] WO_READ_VALUE = 8'hff;
  localparam logic [7:0] GUARD_READ_VALUE = 8'hff;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  // Wishbone register map, one word per byte address (byte address = 4 x index).
  localparam logic [9:0] WB_WORD_LAST = 10'h3ff;
endpackage
`default_nettype wire

// ### rtl/scratch_ram.sv
`timescale 1ns/1ps
`default_nettype none
module scratch_ram
  import regfile_pkg::*;
(
  input wire logic core_clk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] wmask,
  input wire logic pair_we,
  input wire logic [7:0] pair_waddr,
  input wire logic [7:0] pair_wdata,
  input wire logic [7:0] pair_wmask,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  // No reset on purpose: contents must survive every reset.
  logic [7:0] mem [0:255];
  // A cleared mask bit keeps the stored bit, so protected port bits survive any write.
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
    if (pair_we) begin
      mem[pair_waddr] <= (mem[pair_waddr] & ~pair_wmask) | (pair_wdata & pair_wmask);
    end
  end
  assign rdata = mem[raddr];
endmodule // scratch_ram
`default_nettype wire

// ### rtl/addr_former.sv
`timescale 1ns/1ps
`default_nettype none
module addr_former
  import regfile_pkg::*;
(
  input wire logic [7:0] field,
  input wire logic is_work,
  input wire logic [3:0] group_nibble,
  output logic [7:0] addr
);
  always_comb begin
    if (is_work) begin
      addr = {group_nibble, field[3:0]};
    end else if (field[7:4] == DIRECT_WORK_NIBBLE) begin
      addr = {group_nibble, field[3:0]};
    end else begin
      addr = field;
    end
  end
endmodule // addr_former
`default_nettype wire

// ### sim/datapath_model.sv
`timescale 1ns/1ps
`default_nettype none
module datapath_model
  import regfile_pkg::*;
(
  input wire logic core_clk,
  input wire logic [15:0] src_data,
  output logic instr_start,
  output logic [7:0] src_field,
  output logic src_is_work,
  output logic src_word,
  output logic [7:0] dst_field,
  output logic dst_is_work,
  output logic dst_word,
  output logic dst_we,
  output logic [15:0] dst_data,
  output logic set_window_base_instr,
  output logic [7:0] set_window_value
);
  initial begin
    {instr_start, src_field, src_is_work, src_word, dst_field, dst_is_work} = '0;
    {dst_word, dst_we, dst_data, set_window_base_instr, set_window_value} = '0;
  end
  // Destinations are written blind, never read first.
  task automatic wr(input logic [7:0] f, input logic w, wd, input logic [15:0] v);
    @(posedge core_clk);
    {instr_start, dst_field, dst_is_work, dst_word, dst_data} <= {1'b1, f, w, wd, v};
    @(posedge core_clk);
    {instr_start, dst_we} <= 2'b01;
    @(posedge core_clk);
    dst_we <= 1'b0;
    // Stale data is inverted so the block cannot lean on a held value.
    dst_data <= ~v;
  endtask
  task automatic rd(input logic [7:0] f, input logic w, wd, output logic [15:0] q);
    @(posedge core_clk);
    {instr_start, src_field, src_is_work, src_word} <= {1'b1, f, w, wd};
    @(posedge core_clk);
    instr_start <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) q = src_data;
  endtask
  task automatic set_base(input logic [7:0] v);
    @(posedge core_clk);
    {set_window_base_instr, set_window_value} <= {1'b1, v};
    @(posedge core_clk);
    set_window_base_instr <= 1'b0;
  endtask
  // Watchdog mode sits at 0f of bank f and is written first after reset.
  task automatic boot();
    set_base(8'h0f);
    wr(8'h0f, 1'b0, 1'b0, 16'h0000);
    set_base(8'h00);
  endtask
endmodule // datapath_model
`default_nettype wire

// ### sim/banked_register_file_addressing_test.sv
`timescale 1ns/1ps
`default_nettype none
module banked_register_file_addressing_test;
  import regfile_pkg::*;
  logic core_clk = '0, rst_n = '0, guard_option = '0, wb_cyc_i = '0, wb_stb_i = '0;
  logic wb_we_i = '0, instr_start, src_is_work, src_word, dst_is_work, dst_word, dst_we;
  logic set_window_base_instr, guard_active, wb_ack_o;
  logic [11:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [7:0] port01_addr_mask = '0, port_wprotect_mask = '0, src_field, dst_field;
  logic [7:0] set_window_value, window_pointer, a, b, s, n;
  logic [15:0] src_data, dst_data, d, w;
  logic [7:0] wo [6] = '{8'hf3, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9};
  int error_cnt = 0, cmp_count = 0;
  always #50 core_clk = ~core_clk;
  datapath_model dp (.core_clk, .src_data, .instr_start, .src_field, .src_is_work, .src_word,
    .dst_field, .dst_is_work, .dst_word, .dst_we, .dst_data, .set_window_base_instr,
    .set_window_value);
  banked_register_file uut (.core_clk, .rst_n, .instr_start, .src_field, .src_is_work,
    .src_word, .dst_field, .dst_is_work, .dst_word, .dst_we, .dst_data,
    .set_window_base_instr, .set_window_value, .port01_addr_mask, .port_wprotect_mask,
    .guard_option, .src_data, .window_pointer, .guard_active, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t datapath got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_wb(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t bus got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic wr, input logic [9:0] i, input logic [7:0] v);
    int k;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, wr, i, 2'b00, 24'h0, v};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (k >= 20) begin
      error_cnt++;
      stop_test();
    end
  endtask
  initial begin
    repeat (50000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(12063));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    dp.boot();
    for (int i = 0; i < 3; i++) begin
      wb(1'b0, 10'h0fd + 10'(i), 8'h00);
      chk_wb(q, 32'h0);
    end
    b = 8'($urandom);
    wb(1'b1, 10'h0fe, b);
    wb(1'b0, 10'h0fe, 8'h00);
    chk_wb(q, {24'h0, b});
    wb(1'b0, 10'h100, 8'h00);
    chk_wb(q, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      a = 8'h10 + 8'(($urandom % 48) * 2);
      w = 16'($urandom);
      dp.wr(a, 1'b0, 1'b1, w);
      dp.rd(a, 1'b0, 1'b1, d);
      chk(d, w);
      wb(1'b0, {2'b00, a + 8'h01}, 8'h00);
      chk_wb(q, {24'h0, w[7:0]});
      dp.rd(a, 1'b0, 1'b0, d);
      chk({8'h00, d[7:0]}, {8'h00, w[15:8]});
      n = 8'(1 + $urandom % 14);
      dp.set_base({n[3:0], 4'h0});
      @(negedge core_clk) chk({8'h00, window_pointer}, {8'h00, n[3:0], 4'h0});
      b = 8'($urandom);
      dp.wr({4'h0, a[3:0]}, 1'b1, 1'b0, {8'h00, b});
      wb(1'b0, {2'b00, n[3:0], a[3:0]}, 8'h00);
      chk_wb(q, {24'h0, b});
      dp.wr({DIRECT_WORK_NIBBLE, a[7:4]}, 1'b0, 1'b0, {8'h00, ~b});
      dp.rd({4'h0, a[7:4]}, 1'b1, 1'b0, d);
      chk({8'h00, d[7:0]}, {8'h00, ~b});
    end
    dp.set_base(8'h00);
    $display("test addressing done");
    foreach (wo[i]) begin
      wb(1'b1, {2'b00, wo[i]}, 8'h00);
      wb(1'b0, {2'b00, wo[i]}, 8'h00);
      chk_wb(q, {24'h0, WO_READ_VALUE});
    end
    dp.rd(8'hf3, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, WO_READ_VALUE});
    $display("test write only done");
    s = 8'($urandom);
    dp.wr(8'h90, 1'b0, 1'b0, {8'h00, s});
    wb(1'b1, 10'h0fb, 8'h40);
    chk({15'h0, guard_active}, 16'h0);
    @(posedge core_clk) guard_option <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk) chk({15'h0, guard_active}, 16'h1);
    dp.wr(8'h90, 1'b0, 1'b0, {8'h00, ~s});
    dp.rd(8'h90, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, GUARD_READ_VALUE});
    wb(1'b1, 10'h0fb, 8'h00);
    @(negedge core_clk) chk({15'h0, guard_active}, 16'h0);
    dp.rd(8'h90, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, s});
    $display("test guard done");
    dp.wr(8'h00, 1'b0, 1'b0, {8'h00, s});
    dp.wr(8'h02, 1'b0, 1'b0, {8'h00, s});
    b = 8'($urandom);
    n = 8'($urandom);
    @(posedge core_clk) {port01_addr_mask, port_wprotect_mask} <= {b, n};
    dp.rd(8'h00, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, s | b});
    dp.wr(8'h02, 1'b0, 1'b0, {8'h00, ~s});
    dp.rd(8'h02, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, (s & n) | (~s & ~n)});
    $display("test ports done");
    dp.wr(8'h05, 1'b0, 1'b0, {8'h00, s});
    dp.set_base(8'h0c);
    wb(1'b0, 10'h0fd, 8'h00);
    chk_wb(q, 32'h0c);
    dp.wr(8'h05, 1'b0, 1'b0, {8'h00, ~s});
    dp.rd(8'h05, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, ~s});
    dp.set_base(8'h00);
    dp.rd(8'h05, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, s});
    $display("test banks done");
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    dp.boot();
    dp.rd(8'h05, 1'b0, 1'b0, d);
    chk({8'h00, d[7:0]}, {8'h00, s});
    $display("test retention done");
    stop_test();
  end
endmodule // banked_register_file_addressing_test
`default_nettype wire
